// ### src/rpu_top.sv
/*
  ROM read-data patch unit: AHB-Lite register slave plus substitution on ROM read data.
  Assumes HCLK drives clk, one bus master, and the ROM controller returns
  read data in the data phase of the transfer whose address phase we sample.
  Assumes reset is applied at every power-up of the domain, since entries are not retained,
  and that hready already folds in the ROM controller's own ready.
*/
`timescale 1ns/1ns
module rpu_top #(
  parameter int unsigned NUM_ENTRIES = rpu_pkg::NUM_ENTRIES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] rom_rdata,
  input wire logic rom_hreadyout,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] sys_rdata
);
  // Elaboration check: the map holds exactly eight pairs
  if (NUM_ENTRIES != rpu_pkg::NUM_ENTRIES) begin : g_bad_entries
    $error("rpu_top supports eight entries only");
  end

  // Too narrow an index field would alias two entries onto one pair offset
  if ((1 << rpu_pkg::IDX_W) < NUM_ENTRIES) begin : g_bad_idx
    $error("rpu_top index field too narrow");
  end

  // The pair block must end below the flag registers, or reads would alias
  if (rpu_pkg::OFS_PAIR_LAST >= rpu_pkg::OFS_VALID) begin : g_bad_map
    $error("rpu_top pair block overlaps flag registers");
  end

  // A register access must never be mistaken for a patchable ROM read
  if (rpu_pkg::ROM_LAST >= rpu_pkg::REG_BASE) begin : g_bad_rom
    $error("rpu_top ROM range overlaps register window");
  end

  localparam int unsigned N = NUM_ENTRIES;

  // Register map inside the window, byte offsets:
  //   8x     match address of entry x
  //   8x+4   replacement word of entry x
  //   0x40   valid flags, read only, writes ignored
  //   0x44   disable strobe, write only, reads zero
  //   0x48   enable strobe, write only, reads zero
  // Every other offset, and any narrow or misaligned access, answers ERROR.
  //
  // Register access, zero wait states:
  //   edge 0   address phase taken; read data prepared into hrdata_q
  //   cycle 1  data phase: hrdata stands, write data is on hwdata
  //   edge 1   pending write lands in the entry or the flag register
  // A refused access answers ERROR for two cycles with ready low in the first
  // only, so the master sees the error before its next address phase goes out.
  //
  // Patch path:
  //   edge 0   ROM read address captured together with a ROM-read flag
  //   cycle 1  ROM controller drives its word; the mux picks patch or ROM word
  //   edge 1   chosen word registered, visible on sys_rdata in cycle 2
  // The comparators look at the captured address, not the live one, because the
  // live bus already carries the next address phase during the data phase.
  // Limitation: the register stage adds one cycle to every ROM read, so whoever
  // consumes sys_rdata must take it one cycle after the ROM data phase.
  // Entry contents live in ordinary flops and are lost with power; software
  // reprograms them after every power-up.

  // Address phase capture
  logic wr_pend_q, wr_pend_d; // Register write pending for data phase
  logic [9:0] wofs_q, wofs_d; // Offset of pending write
  logic rom_rd_q, rom_rd_d; // Current data phase is a ROM read
  logic [31:0] rom_addr_q, rom_addr_d; // Address of that ROM read
  logic [31:0] hrdata_q, hrdata_d; // Register read data
  rpu_pkg::rpu_rsp_t rsp_q, rsp_d; // Reply state
  logic hresp_q, hresp_d; // Error reply pin as registered
  logic hreadyout_q, hreadyout_d; // Ready pin as registered, low only in the first error cycle
  logic [7:0] valid_q, valid_d; // Entry valid flags
  logic [31:0] sys_rdata_q, sys_rdata_d; // Registered read data toward the CPU

  // Decode helpers
  logic active; // Address phase accepted
  logic reg_hit; // Address falls in our window
  logic [9:0] aofs; // Offset within window
  logic ofs_ok; // Offset maps to a register
  logic size_ok; // Only word transfers accepted
  logic [rpu_pkg::IDX_W-1:0] rd_idx; // Entry named by a pair read

  // Entry interface
  logic [N-1:0] addr_we, data_we, done, hit;
  logic [N*32-1:0] words;
  logic [31:0] match_addr [N];
  logic sel_any;
  logic [31:0] sel_word;

  // A phase counts only once the previous data phase is done (hready);
  // htrans[1] covers NONSEQ and SEQ, so IDLE and BUSY are ignored
  assign active = hsel && hready && htrans[1];
  assign aofs = haddr[9:0];
  // Window decode
  assign reg_hit = rpu_pkg::in_range(haddr, rpu_pkg::REG_BASE, rpu_pkg::REG_LAST);
  // Entries have no byte lanes, so a narrow write would corrupt them
  assign size_ok = (hsize == 3'h2) && (haddr[1:0] == 2'h0);

  // Entry index held in a pair offset; used by the read and the write path
  function automatic logic [rpu_pkg::IDX_W-1:0] pair_idx(input logic [9:0] o);
    pair_idx = o[rpu_pkg::OFS_IDX_LSB +: rpu_pkg::IDX_W];
  endfunction : pair_idx

  // True when an offset falls in the block of address/data pairs
  function automatic logic is_pair(input logic [9:0] o);
    is_pair = (o <= rpu_pkg::OFS_PAIR_LAST);
  endfunction : is_pair

  // Offset map check, shared by read and write paths
  function automatic logic ofs_mapped(input logic [9:0] o);
    ofs_mapped = is_pair(o) || (o == rpu_pkg::OFS_VALID) ||
                 (o == rpu_pkg::OFS_DISABLE) || (o == rpu_pkg::OFS_ENABLE);
  endfunction : ofs_mapped

  assign ofs_ok = ofs_mapped(aofs) && size_ok;
  assign rd_idx = pair_idx(aofs);

  // Entries: consecutive address/data pairs
  for (genvar g = 0; g < N; g++) begin : g_entry
    logic [31:0] ra;
    logic [31:0] rw;
    logic this_pair;
    // The genvar is cast to the index width so both sides of the compare match
    assign this_pair = wr_pend_q && is_pair(wofs_q) &&
                       (pair_idx(wofs_q) == (rpu_pkg::IDX_W)'(g));
    // Write decode for pair g
    assign addr_we[g] = this_pair && !wofs_q[rpu_pkg::OFS_SEL_BIT];
    assign data_we[g] = this_pair && wofs_q[rpu_pkg::OFS_SEL_BIT];
    rpu_entry u_entry (
      .clk(clk),
      .arst_n(arst_n),
      .addr_we(addr_we[g]),
      .data_we(data_we[g]),
      .wdata(hwdata),
      .bus_addr(rom_addr_q),
      .match_addr(ra),
      .repl_word(rw),
      .both_written(done[g]),
      .hit(hit[g])
    );
    assign match_addr[g] = ra;
    assign words[g*32 +: 32] = rw;
  end

  // One pass over all hits; the last hit found is kept, which gives the
  // highest-numbered entry the top rank without a separate encoder
  rpu_select #(.N(N)) u_sel (
    .hit(hit),
    .valid(valid_q),
    .words(words),
    .any(sel_any),
    .word(sel_word)
  );

  // Bus slave next state: address phase capture, reply, read mux
  always_comb begin
    wr_pend_d = 1'b0;
    wofs_d = wofs_q;
    hrdata_d = hrdata_q;
    rsp_d = rpu_pkg::RPU_RSP_OKAY;
    // Two-cycle error reply, second cycle releases ready
    if (rsp_q == rpu_pkg::RPU_RSP_ERR1) begin
      // Ready is low now, so no address phase can be taken in this cycle
      rsp_d = rpu_pkg::RPU_RSP_ERR2;
    end else if (active && reg_hit) begin
      if (!ofs_ok) begin
        // Hole in the map, narrow or misaligned access: refuse it
        rsp_d = rpu_pkg::RPU_RSP_ERR1;
      end else if (hwrite) begin
        // Write data arrives only in the data phase, so park the offset
        wr_pend_d = 1'b1;
        wofs_d = aofs;
      end else begin
        // Read data prepared now, presented in data phase
        if (is_pair(aofs)) begin
          // Odd word of a pair is the replacement word, even word the address
          hrdata_d = aofs[rpu_pkg::OFS_SEL_BIT] ? words[rd_idx*32 +: 32] : match_addr[rd_idx];
        end else if (aofs == rpu_pkg::OFS_VALID) begin
          // Flags sit in the low byte, upper bits read as zero
          hrdata_d = {24'h00_0000, valid_q};
        end else begin
          // Strobe registers are write-only and read as zero
          hrdata_d = rpu_pkg::WORD_RST;
        end
      end
    end
    // Reply pins follow the next reply state, so both leave a flop directly
    hresp_d = (rsp_d != rpu_pkg::RPU_RSP_OKAY) ? rpu_pkg::HRESP_ERROR : rpu_pkg::HRESP_OKAY;
    hreadyout_d = (rsp_d != rpu_pkg::RPU_RSP_ERR1);
  end

  // Bus slave state on the bus clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wofs_q <= 10'h000;
      hrdata_q <= rpu_pkg::WORD_RST;
      rsp_q <= rpu_pkg::RPU_RSP_OKAY;
      hresp_q <= rpu_pkg::HRESP_OKAY;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_pend_d;
      wofs_q <= wofs_d;
      hrdata_q <= hrdata_d;
      rsp_q <= rsp_d;
      hresp_q <= hresp_d;
      hreadyout_q <= hreadyout_d;
    end
  end

  // Valid flags: completion and enable set, disable clears; set wins
  // A disable that meets the data write completing the same entry loses, so a
  // freshly programmed entry is never dropped by a stale mask; software that
  // wants it off writes the disable register again afterwards.
  always_comb begin
    valid_d = valid_q;
    if (wr_pend_q && wofs_q == rpu_pkg::OFS_DISABLE) begin
      valid_d = valid_d & ~hwdata[7:0];
    end
    if (wr_pend_q && wofs_q == rpu_pkg::OFS_ENABLE) begin
      valid_d = valid_d | hwdata[7:0];
    end
    valid_d = valid_d | done;
  end

  // Flag register; reset leaves every entry disabled until software reprograms it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= rpu_pkg::VALID_RST;
    end else begin
      valid_q <= valid_d;
    end
  end

  // Patch path next state: track ROM reads, then choose the word in their data phase
  always_comb begin
    rom_rd_d = rom_rd_q;
    rom_addr_d = rom_addr_q;
    // A stretched data phase keeps the captured address; the ROM controller may insert waits
    if (hready) begin
      // Writes and addresses outside the ROM never arm the mux
      rom_rd_d = htrans[1] && !hwrite && rpu_pkg::in_range(haddr, rpu_pkg::ROM_BASE, rpu_pkg::ROM_LAST);
      rom_addr_d = haddr;
    end
    // Substitution on ROM read data only
    sys_rdata_d = rom_rdata;
    if (rom_rd_q && sel_any) begin
      // Highest enabled hit, already chosen by the selector
      sys_rdata_d = sel_word;
    end
  end

  // Patch path registers; the output lags the ROM word by one cycle for a flop-driven pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_rd_q <= 1'b0;
      rom_addr_q <= rpu_pkg::WORD_RST;
      sys_rdata_q <= rpu_pkg::WORD_RST;
    end else begin
      rom_rd_q <= rom_rd_d;
      rom_addr_q <= rom_addr_d;
      sys_rdata_q <= sys_rdata_d;
    end
  end

  // Every pin comes straight from a flop
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign hreadyout = hreadyout_q;
  assign sys_rdata = sys_rdata_q;

  // The ROM controller's own ready is already folded into the bus-wide hready
  logic unused_ok;
  assign unused_ok = rom_hreadyout;
endmodule : rpu_top

// ### src/rpu_pkg.sv
/*
  Package for the ROM read-data patch unit: register map, widths, address windows.
  Assumes a 32-bit AHB-Lite system bus with byte addresses.
*/
package rpu_pkg;
  // Entry count and word width
  localparam int unsigned NUM_ENTRIES = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 3;

  // Register window on the system bus
  localparam logic [31:0] REG_BASE = 32'h4000_8400;
  localparam logic [31:0] REG_LAST = 32'h4000_87FF;

  // Patchable ROM range
  localparam logic [31:0] ROM_BASE = 32'h0000_0000;
  localparam logic [31:0] ROM_LAST = 32'h0001_4FFF;

  // Register byte offsets inside the window (pairs at 8-byte stride)
  localparam logic [9:0] OFS_PAIR_BASE = 10'h000;
  localparam logic [9:0] OFS_PAIR_LAST = 10'h03C;
  localparam logic [9:0] OFS_VALID = 10'h040;
  localparam logic [9:0] OFS_DISABLE = 10'h044;
  localparam logic [9:0] OFS_ENABLE = 10'h048;

  // Field positions of a pair offset
  localparam int unsigned OFS_SEL_BIT = 2;
  localparam int unsigned OFS_IDX_LSB = 3;

  // AHB transfer type codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // AHB response codes
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic HRESP_ERROR = 1'h1;

  // Reset values
  localparam logic [7:0] VALID_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Reply state of the register slave
  typedef enum logic [1:0] {
    RPU_RSP_OKAY,
    RPU_RSP_ERR1,
    RPU_RSP_ERR2
  } rpu_rsp_t;

  // Window membership test shared by decoders
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range
endpackage : rpu_pkg

// ### src/rpu_entry.sv
/*
  One patch entry: match address, replacement word, written-tracking and comparator.
  Assumes write strobes come from the register slave on the same clock.
*/
`timescale 1ns/1ns
module rpu_entry (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic addr_we,
  input wire logic data_we,
  input wire logic [31:0] wdata,
  input wire logic [31:0] bus_addr,
  output logic [31:0] match_addr,
  output logic [31:0] repl_word,
  output logic both_written,
  output logic hit
);
  logic [31:0] addr_q, addr_d; // Match address
  logic [31:0] data_q, data_d; // Replacement word
  logic addr_seen_q, addr_seen_d; // Address half written since last completion

  // Next values: address first, then data completes the pair
  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    addr_seen_d = addr_seen_q;
    both_written = 1'b0;
    if (addr_we) begin
      addr_d = wdata;
      addr_seen_d = 1'b1;
    end
    if (data_we) begin
      data_d = wdata;
      // Completion flags the pair; a data write alone does not
      both_written = addr_seen_q;
      addr_seen_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= rpu_pkg::WORD_RST;
      data_q <= rpu_pkg::WORD_RST;
      addr_seen_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
      addr_seen_q <= addr_seen_d;
    end
  end

  // Comparator, one per entry so all run in parallel
  assign hit = (bus_addr == addr_q);
  assign match_addr = addr_q;
  assign repl_word = data_q;
endmodule : rpu_entry

// ### src/rpu_select.sv
/*
  Priority selector: picks the highest-numbered enabled hit.
  Assumes hit and valid vectors are aligned per entry index.
*/
`timescale 1ns/1ns
module rpu_select #(
  parameter int unsigned N = 8
) (
  input wire logic [N-1:0] hit,
  input wire logic [N-1:0] valid,
  input wire logic [N*32-1:0] words,
  output logic any,
  output logic [31:0] word
);
  // Later entries overwrite earlier, so entry N-1 wins
  always_comb begin
    any = 1'b0;
    word = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (hit[i] && valid[i]) begin
        any = 1'b1;
        word = words[i*32 +: 32];
      end
    end
  end
endmodule : rpu_select

// ### dv/rpu_checker.sv
/*
  Port-level checker for the ROM patch unit: bus replies and raw pass-through.
  Assumes one clock domain and attaches to rpu_top by the bind at the foot.
*/
`timescale 1ns/1ns
module rpu_checker #(
  parameter int unsigned NUM_ENTRIES = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] rom_rdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] sys_rdata
);
  // Register access accepted this cycle
  wire logic reg_ap = hsel && hready && htrans[1];
  // Word read of a given register, used by the read-value checks
  wire logic rd_ap = reg_ap && !hwrite && hsize == 3'h2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  err_two_cycle_a: assert property ($rose(hresp) |-> !hreadyout ##1 (hresp && hreadyout))
    else $error("error reply not two cycles");
  wait_only_err_a: assert property (!hreadyout |-> hresp)
    else $error("wait state without error");
  size_err_a: assert property (reg_ap && hsize != 3'h2 |=> hresp && !hreadyout)
    else $error("non-word access accepted");
  hole_err_a: assert property (rd_ap && haddr > 32'h4000_8448 && haddr <= rpu_pkg::REG_LAST |=> hresp)
    else $error("unmapped offset accepted");
  idle_ok_a: assert property (hready && !reg_ap |=> !hresp)
    else $error("error without register access");
  strobe_zero_a: assert property (rd_ap && (haddr == 32'h4000_8444 || haddr == 32'h4000_8448) |=> hrdata == 0)
    else $error("strobe register read not zero");
  valid_width_a: assert property (rd_ap && haddr == 32'h4000_8440 |=> hrdata[31:8] == 24'h0)
    else $error("valid flags wider than entries");
  raw_pass_a: assert property (hready && htrans[1] && (hwrite || haddr > rpu_pkg::ROM_LAST)
    |-> ##2 sys_rdata == $past(rom_rdata))
    else $error("non-ROM read data altered");
  // Main scenarios
  cov_err: cover property ($rose(hresp));
  cov_patch: cover property (hready && htrans[1] && !hwrite ##2 sys_rdata != $past(rom_rdata));
  cov_strobe: cover property (rd_ap && haddr == 32'h4000_8444);
endmodule : rpu_checker

bind rpu_top rpu_checker #(.NUM_ENTRIES(NUM_ENTRIES)) rpu_checker_inst (.clk(clk), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .rom_rdata(rom_rdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_rdata(sys_rdata));

// ### dv/rpu_rom_model.sv
/*
  ROM controller stand-in: returns the inverted address as the stored word.
  Assumes zero-wait ROM reads answered in the data phase.
*/
`timescale 1ns/1ns
module rpu_rom_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic [31:0] rom_rdata
);
  logic [31:0] word_q; // Data bus as driven
  logic [31:0] word_d;
  // Undriven bus toggles so stale data can never pass for a match
  always_comb begin
    word_d = ~word_q;
    if (hready && htrans[1] && !hwrite && haddr <= rpu_pkg::ROM_LAST) begin
      word_d = ~haddr;
    end
  end
  // Data phase register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_q <= 32'h0000_0000;
    end else begin
      word_q <= word_d;
    end
  end
  assign rom_rdata = word_q;
endmodule : rpu_rom_model

// ### dv/rpu_top_tb_top.sv
/*
  Testbench for the ROM patch unit: bus master tasks and directed sequences.
  Assumes the ROM model answers reads and the unit is the only slave on hready.
*/
`timescale 1ns/1ns
module rpu_top_tb_top;
  localparam logic [31:0] RB = rpu_pkg::REG_BASE;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rom_rdata, hrdata, sys_rdata, rdv;
  logic hreadyout, hresp, erv;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  rpu_top rpu_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .rom_rdata(rom_rdata),
    .rom_hreadyout(1'b1), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_rdata(sys_rdata));
  rpu_rom_model rpu_rom_model_inst (.clk(clk), .arst_n(arst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hreadyout), .rom_rdata(rom_rdata));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task close_out;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // One transfer; sel low makes it a ROM-side access; waits are bounded
  task xfer(input logic sel, input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
    int n;
    @(posedge clk);
    #1 hsel = sel;
    haddr = a;
    htrans = 2'h2;
    hwrite = w;
    hsize = sz;
    @(posedge clk);
    #1 hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    // Reply is looked at while settled, before the edge that samples it
    n = 0;
    while (hreadyout !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    if (hreadyout !== 1'b1) err_total++;
    rdv = hrdata;
    erv = hresp;
    // Data phase ends at this edge
    @(posedge clk);
  endtask : xfer
  task rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b1, 1'b0, a, 32'h0, 3'h2);
    chk(rdv, exp);
  endtask : rd
  // ROM read: the chosen word stands in the cycle after the data phase
  task rom(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, 1'b0, a, 32'h0, 3'h2);
    #1 chk(sys_rdata, exp);
  endtask : rom
  initial begin
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(RB + 32'h40, 32'h0);
    // Entries i and i+4 share an address so the upper one must win
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 1'b1, RB + 32'(8 * i), 32'h100 + 32'(4 * (i % 4)), 3'h2);
      rd(RB + 32'h40, (32'h1 << i) - 32'h1);
      xfer(1'b1, 1'b1, RB + 32'(8 * i + 4), 32'hD000_0000 + 32'(i), 3'h2);
      rd(RB + 32'h40, (32'h2 << i) - 32'h1);
      rd(RB + 32'(8 * i), 32'h100 + 32'(4 * (i % 4)));
    end
    for (int j = 0; j < 4; j++) rom(32'h100 + 32'(4 * j), 32'hD000_0004 + 32'(j));
    rom(32'h0001_4FFC, ~32'h0001_4FFC);
    xfer(1'b1, 1'b1, RB + 32'h44, 32'hF0, 3'h2);
    rd(RB + 32'h40, 32'h0F);
    rom(32'h100, 32'hD000_0000);
    xfer(1'b1, 1'b1, RB + 32'h48, 32'h10, 3'h2);
    rd(RB + 32'h40, 32'h1F);
    rom(32'h100, 32'hD000_0004);
    xfer(1'b1, 1'b1, RB + 32'h40, 32'h0, 3'h2);
    rd(RB + 32'h40, 32'h1F);
    rd(RB + 32'h44, 32'h0);
    xfer(1'b1, 1'b0, RB + 32'h4C, 32'h0, 3'h2);
    chk({31'h0, erv}, 32'h1);
    xfer(1'b1, 1'b0, RB + 32'h40, 32'h0, 3'h0);
    chk({31'h0, erv}, 32'h1);
    xfer(1'b1, 1'b0, RB + 32'h41, 32'h0, 3'h2);
    chk({31'h0, erv}, 32'h1);
    xfer(1'b0, 1'b1, 32'h100, 32'h0, 3'h2);
    // Second reset mid-run must drop every patch
    #1 arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(RB + 32'h40, 32'h0);
    rom(32'h100, ~32'h100);
    // Software reprograms after the reset and the patch returns
    xfer(1'b1, 1'b1, RB + 32'h28, 32'h104, 3'h2);
    xfer(1'b1, 1'b1, RB + 32'h2C, 32'hD000_0055, 3'h2);
    rom(32'h104, 32'hD000_0055);
    close_out;
  end
  // Hang guard; the run needs well under 1000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      close_out;
    end
  end
endmodule : rpu_top_tb_top
